//--- dao_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// fifo
module dao_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("depth must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  assign in_ready_out = cnt_r != CW'(DEPTH);
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = mem_r[rp_r];
  assign level_out = cnt_r;
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// ==========================================
// converter output sequencer
module dao_sequencer #(
  parameter int CODE_W = dao_pkg::CODE_W,
  parameter int DIN_W = dao_pkg::DIN_W,
  parameter int FIFO_DEPTH = dao_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic conv_clk_in,
  input wire logic signed [DIN_W-1:0] chan_a_in,
  input wire logic signed [DIN_W-1:0] chan_b_in,
  output logic [CODE_W-1:0] chan_a_out,
  output logic [CODE_W-1:0] chan_b_out,
  output logic chan_ind_out,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  initial begin
    if (CODE_W != 10 || DIN_W != 12) begin
      $error("code width 10 and input width 12 only");
    end
  end
  localparam int LW = $clog2(FIFO_DEPTH+1);

  function automatic logic signed [11:0] dao_scale(
    input logic signed [11:0] v,
    input logic g
  );
    return g ? (v >>> 1) : v;
  endfunction

  function automatic logic [9:0] dao_quant(
    input logic signed [11:0] v,
    input logic g
  );
    logic signed [11:0] s;
    s = dao_scale(v, g);
    if (s < dao_pkg::IN_MIN) begin
      return dao_pkg::CODE_NEG_FS;
    end else if (s > dao_pkg::IN_MAX) begin
      return dao_pkg::CODE_POS_FS;
    end
    return 10'(s + dao_pkg::CODE_MID);
  endfunction

  // ==========================================
  // input synchronisers
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic signed [11:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r;
  always_ff @(posedge clk_sys_in) begin
    ck_s1_r <= conv_clk_in;
    ck_s2_r <= ck_s1_r;
    ck_s3_r <= ck_s2_r;
    a_s1_r <= chan_a_in;
    a_s2_r <= a_s1_r;
    b_s1_r <= chan_b_in;
    b_s2_r <= b_s1_r;
  end
  wire rise_evt = ck_s2_r & ~ck_s3_r;
  wire fall_evt = ~ck_s2_r & ck_s3_r;

  // ==========================================
  // registers
  logic [3:0] ctrl_r;
  logic ovf_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] count_r;
  wire obs = ctrl_r[dao_pkg::CTRL_OBS];
  wire gain = ctrl_r[dao_pkg::CTRL_RANGE];
  wire run = ~ctrl_r[dao_pkg::CTRL_PD] & ~ctrl_r[dao_pkg::CTRL_STANDBY_PIN];
  wire req = avs_read | avs_write;
  wire acc = req & ack_r;
  wire sel_ctrl = avs_address == dao_pkg::OFS_CTRL;
  wire sel_st = avs_address == dao_pkg::OFS_STATUS;
  wire sel_data = avs_address == dao_pkg::OFS_DATA;
  wire sel_cnt = avs_address == dao_pkg::OFS_COUNT;
  wire wr_ctrl = acc & avs_write & sel_ctrl & avs_byteenable[0];
  wire clr_ovf = acc & avs_write & sel_st & avs_byteenable[0] &
    avs_writedata[dao_pkg::ST_OVF];
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // ==========================================
  // fifo of results
  logic fifo_in_ready, fifo_out_valid;
  logic [19:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic push;
  wire pop = acc & avs_read & sel_data;
  wire [31:0] st_word = {16'h0000, 3'b000, 5'(fifo_level), 5'b00000,
    ovf_r, fifo_out_valid, run};
  wire [31:0] rd_mux = sel_ctrl ? {28'h0000000, ctrl_r} :
    sel_st ? st_word :
    sel_data ? {12'h000, fifo_out_data} :
    sel_cnt ? count_r : dao_pkg::RD_ZERO;

  // ==========================================
  // conversion pipeline
  logic [2:0][9:0] pa_r, pb_r;
  logic [2:0] pv_r;
  logic [9:0] hold_b_r;
  logic hold_v_r;
  logic [9:0] a_out_r, b_out_r;
  logic ind_r;
  wire [9:0] qa = dao_quant(a_s2_r, gain);
  wire [9:0] qb = dao_quant(b_s2_r, gain);
  wire samp = fall_evt & run;
  wire out_evt = rise_evt & pv_r[2];
  assign chan_a_out = a_out_r;
  assign chan_b_out = b_out_r;
  assign chan_ind_out = ind_r;
  assign push = out_evt;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pv_r <= '0;
      pa_r <= '0;
      pb_r <= '0;
    end else if (!run) begin
      pv_r <= '0;
    end else if (samp) begin
      pa_r <= {pa_r[1:0], qa};
      pb_r <= {pb_r[1:0], qb};
      pv_r <= {pv_r[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      a_out_r <= '0;
      b_out_r <= '0;
      hold_b_r <= '0;
      hold_v_r <= 1'b0;
      ind_r <= 1'b0;
    end else if (out_evt) begin
      a_out_r <= pa_r[2];
      b_out_r <= obs ? pb_r[2] : b_out_r;
      hold_b_r <= pb_r[2];
      hold_v_r <= ~obs;
      ind_r <= 1'b1;
    end else if (fall_evt && hold_v_r) begin
      a_out_r <= hold_b_r;
      hold_v_r <= 1'b0;
      ind_r <= 1'b0;
    end
  end

  // ==========================================
  // bus slave
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_r <= dao_pkg::CTRL_RST;
      ack_r <= 1'b0;
      rdata_r <= '0;
      ovf_r <= 1'b0;
      count_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rdata_r <= avs_read ? rd_mux : dao_pkg::RD_ZERO;
      end
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[3:0];
      end
      if (push && !fifo_in_ready) begin
        ovf_r <= 1'b1;
      end else if (clr_ovf) begin
        ovf_r <= 1'b0;
      end
      count_r <= count_r + 32'(push);
    end
  end

  dao_fifo #(
    .WIDTH(20),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({pb_r[2], pa_r[2]}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_out_data),
    .level_out(fifo_level)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_sample_fall: assert property (
    $rose(pv_r[0]) |-> $past(fall_evt))
    else $error("sample taken off a falling edge");
  a_par_rise: assert property (
    obs && $changed(b_out_r) |-> $past(rise_evt))
    else $error("parallel bus moved off a rising edge");
  a_mux_first: assert property (
    !obs && $rose(ind_r) |-> $past(rise_evt) && a_out_r == $past(pa_r[2]))
    else $error("first channel word wrong");
  a_par_latency: assert property (
    out_evt && obs |=> a_out_r == $past(pa_r[2]) && b_out_r == $past(pb_r[2]))
    else $error("parallel result not presented");
  a_mux_second: assert property (
    $fell(ind_r) |-> $past(fall_evt) && a_out_r == $past(hold_b_r))
    else $error("second channel word wrong");
  a_stop_conv: assert property (
    !run |=> pv_r == 3'b000)
    else $error("conversion while stopped");
  a_neg_clamp: assert property (
    samp && dao_scale(a_s2_r, gain) < dao_pkg::IN_MIN
    |=> pa_r[0] == dao_pkg::CODE_NEG_FS)
    else $error("under range not clamped");
  a_pos_clamp: assert property (
    samp && dao_scale(a_s2_r, gain) > dao_pkg::IN_MAX
    |=> pa_r[0] == dao_pkg::CODE_POS_FS)
    else $error("over range not clamped");
  a_code_gain: assert property (
    samp && gain && a_s2_r == 12'sh004 |=> pa_r[0] == 10'h202)
    else $error("range select step wrong");
  a_ind_hold: assert property (
    !obs && ind_r && !fall_evt |=> ind_r)
    else $error("indicator dropped early");
  a_bus_ack: assert property (
    req |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

//--- dao_pkg.sv
`default_nettype none
// ==========================================
// shared constants
package dao_pkg;
  localparam int CODE_W = 10;
  localparam int DIN_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int PIPE_STG = 3;
  // code limits, offset binary
  localparam logic signed [11:0] IN_MIN = -12'sh200;
  localparam logic signed [11:0] IN_MAX = 12'sh1ff;
  localparam logic signed [11:0] CODE_MID = 12'sh200;
  localparam logic [9:0] CODE_NEG_FS = 10'h000;
  localparam logic [9:0] CODE_POS_FS = 10'h3ff;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hc;
  // ctrl fields
  localparam int CTRL_OBS = 0;
  localparam int CTRL_RANGE = 1;
  localparam int CTRL_PD = 2;
  localparam int CTRL_STANDBY_PIN = 3;
  localparam logic [3:0] CTRL_RST = 4'h1;
  // status fields
  localparam int ST_RUN = 0;
  localparam int ST_NEMPTY = 1;
  localparam int ST_OVF = 2;
  localparam int ST_LVL = 8;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

//--- dao_rx.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// receiver latching mux words
module dao_rx (
  input wire logic clk_sys_in,
  input wire logic [9:0] word_in,
  input wire logic ind_in,
  output logic [9:0] a_word_out,
  output logic [9:0] b_word_out
);
  logic ind_r;
  always_ff @(posedge clk_sys_in) begin
    ind_r <= ind_in;
    if (ind_in && !ind_r) begin
      a_word_out <= word_in;
    end
    if (!ind_in && ind_r) begin
      b_word_out <= word_in;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module tb;
  logic clk_sys_in = 1'h0, rst_in = 1'h1, conv_clk_in = 1'h0;
  logic signed [11:0] chan_a_in = 12'sh000, chan_b_in = 12'sh000;
  logic [9:0] chan_a_out, chan_b_out, rx_a, rx_b;
  logic chan_ind_out, avs_waitrequest;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, q0;
  int miscompares = 0, checked = 0, cyc = 0;
  dao_sequencer dao_sequencer_i (.clk_sys_in, .rst_in, .conv_clk_in,
    .chan_a_in, .chan_b_in, .chan_a_out, .chan_b_out, .chan_ind_out,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  dao_rx dao_rx_i (.clk_sys_in, .word_in(chan_a_out),
    .ind_in(chan_ind_out), .a_word_out(rx_a), .b_word_out(rx_b));
  always #2.5 clk_sys_in = ~clk_sys_in;
  // conversion clock, 16 system cycles a period
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    conv_clk_in <= cyc[3];
    if (cyc == 10000) begin
      miscompares++;
      close_out();
    end
  end
  task close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge clk_sys_in); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  function automatic logic [31:0] code(input int v, input logic g);
    int s;
    s = g ? v >>> 1 : v;
    if (s < -512) return 32'h0;
    if (s > 511) return 32'h3ff;
    return 32'(s + 512);
  endfunction
  task wait_fall();
    do @(posedge clk_sys_in); while (conv_clk_in !== 1'h1);
    do @(posedge clk_sys_in); while (conv_clk_in !== 1'h0);
  endtask
  // ====================
  // scenarios
  task t_regs();
    bus(1'h0, 4'h0, 32'h0);
    chk("ctrl", 32'h1, rd);
    bus(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task t_codes();
    int v[7] = '{-513, 511, 100, 100, -1100, 1100, 4};
    logic g[7] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
    for (int i = 0; i < 7; i++) begin
      bus(1'h1, 4'h0, {30'h0, g[i], 1'h1});
      chan_a_in <= 12'(v[i]);
      chan_b_in <= 12'(-v[i]);
      tick(100);
      chk("code a", code(v[i], g[i]), 32'(chan_a_out));
      chk("code b", code(-v[i], g[i]), 32'(chan_b_out));
    end
  endtask
  task t_lat(input logic m);
    bus(1'h1, 4'h0, {31'h0, ~m});
    chan_a_in <= 12'sh000;
    chan_b_in <= 12'sh000;
    tick(100);
    wait_fall();
    tick(4);
    chan_a_in <= 12'sh064;
    chan_b_in <= -12'sh064;
    wait_fall();
    tick(40);
    chk("before", 32'h200, 32'(chan_a_out));
    tick(8);
    chk("first", 32'h264, 32'(chan_a_out));
    chk("ind first", 32'h1, 32'(chan_ind_out));
    if (!m) chk("par b", 32'h19c, 32'(chan_b_out));
    tick(8);
    chk("second", m ? 32'h19c : 32'h264, 32'(chan_a_out));
    chk("ind second", {31'h0, ~m}, 32'(chan_ind_out));
    if (m) chk("rx", 32'h0009919c, {12'h0, rx_a, rx_b});
  endtask
  task t_rate();
    logic [31:0] cv[3] = '{32'h1, 32'h5, 32'h9};
    for (int k = 0; k < 3; k++) begin
      bus(1'h1, 4'h0, cv[k]);
      tick(100);
      bus(1'h0, 4'hc, 32'h0);
      q0 = rd;
      tick(125);
      bus(1'h0, 4'hc, 32'h0);
      chk("count", k == 0 ? q0 + 32'h8 : q0, rd);
    end
  endtask
  // inputs still hold 100 and -100 from the mux run
  task t_fifo();
    int n;
    for (int p = 0; p < 2; p++) begin
      bus(1'h1, 4'h0, 32'h9);
      tick(100);
      n = 0;
      bus(1'h0, 4'h4, 32'h0);
      while (rd[1] === 1'h1 && n < 40) begin
        bus(1'h0, 4'h8, 32'h0);
        if (p == 1) chk("pop", 32'h67264, rd);
        n++;
        bus(1'h0, 4'h4, 32'h0);
      end
      if (p == 0) begin
        bus(1'h1, 4'h4, 32'h4);
        bus(1'h1, 4'h0, 32'h1);
        tick(320);
        bus(1'h0, 4'h4, 32'h0);
        chk("full", 32'h1007, rd & 32'h1f07);
      end
    end
    chk("level", 32'h10, 32'(n));
    bus(1'h1, 4'h4, 32'h4);
    bus(1'h0, 4'h4, 32'h0);
    chk("empty", 32'h0, rd);
  endtask
  initial begin
    tick(10);
    rst_in <= 1'h0;
    tick(1);
    t_regs();
    t_codes();
    t_lat(1'h0);
    t_lat(1'h1);
    t_rate();
    t_fifo();
    close_out();
  end
endmodule
`default_nettype wire
